// file: rtl/fan_ctrl_defines.svh
`ifndef FAN_CTRL_DEFINES_SVH
`define FAN_CTRL_DEFINES_SVH

// ==================================================
// register byte offsets
`define REG_CTRL_OFS 4'h0
`define REG_STATUS_OFS 4'h4
`define REG_MASK_OFS 4'h8
`define REG_STATE_OFS 4'hC

// ==================================================
// control register fields
`define CTRL_AUTO_BIT 0
`define CTRL_LOW_LSB 2
`define CTRL_LOW_MSB 3
`define CTRL_SPAN_LSB 4
`define CTRL_SPAN_MSB 6
`define CTRL_RESET 7'h00

// ==================================================
// event bits in status and mask
`define EV_FAULT 0
`define EV_ALERT_SET 1
`define EV_ALERT_CLR 2
`define EV_KICK 3
`define EV_RETRY 4
`define EV_WIDTH 5
`define EV_RESET 5'h00

// ==================================================
// temperatures in degrees C and threshold code limits
`define TL_BASE_C 8'h19
`define TH_STEP_C 8'h05
`define MIN_SPAN_C 8'h0A
`define OVER_TRIP_C 8'h0A
`define OVER_HYST_C 8'h05
`define STEP_BASE_C 4'h2
`define LOW_CODE_MAX 2'h2
`define SPAN_CODE_MAX 3'h4

// ==================================================
// timing
`define CLK_HZ 50000000
`define PWM_FREQ_HZ 15
`define PWM_SLOTS 10
`define SLOT_CYCLES (`CLK_HZ / (`PWM_FREQ_HZ * `PWM_SLOTS))
`define STARTUP_TIME_MS 2000
`define STARTUP_PERIODS (`STARTUP_TIME_MS * `PWM_FREQ_HZ / 1000)
`define MISS_PERIODS 32
`define BLANK_TIME_US 500
`define BLANK_CYCLES (`BLANK_TIME_US * (`CLK_HZ / 1000000))

// ==================================================
// duty in tenths
`define DUTY_MIN 4'h4
`define DUTY_OFFSET 4'h4
`define DUTY_OFF 4'h0
`define DUTY_FULL 4'hA

`endif

// file: rtl/fan_ctrl_pkg.sv
package fan_ctrl_pkg;
    // duty in tenths of a period
    typedef logic [3:0] duty_t;
    // fan drive state
    typedef enum logic [2:0] {
        ST_SHUT,
        ST_FAULTED,
        ST_AUTO_OFF,
        ST_KICK,
        ST_RUN
    } fan_state_t;
endpackage

// file: rtl/pwm_tb_if.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// duty request and period timing between controller and timebase
interface pwm_tb_if;
    import fan_ctrl_pkg::*;
    duty_t duty;       // requested duty, tenths
    logic period_tick; // one cycle at each period start
    logic pwm_on;      // raw duty waveform
    modport gen(input duty, output period_tick, output pwm_on);
    modport user(output duty, input period_tick, input pwm_on);
endinterface
`default_nettype wire

// file: rtl/pwm_timebase.sv
`timescale 1ns/100ps
`default_nettype none
`include "fan_ctrl_defines.svh"
// ==================================================
// slot divider and duty waveform
module pwm_timebase
    import fan_ctrl_pkg::*;
#(
    parameter int SLOT_CYCLES = `SLOT_CYCLES,
    parameter int SLOTS = `PWM_SLOTS
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    pwm_tb_if.gen tb
);
    localparam int CW = $clog2(SLOT_CYCLES + 1);
    localparam int SW = $clog2(SLOTS + 1);

    logic [CW-1:0] cyc_r;   // cycles within slot
    logic [SW-1:0] slot_r;  // slot within period
    logic tick_r;           // period start pulse
    logic on_r;             // waveform

    wire slot_end = (cyc_r == CW'(SLOT_CYCLES - 1));
    wire period_end = slot_end && (slot_r == SW'(SLOTS - 1));
    wire [SW-1:0] slot_nxt = period_end ? '0 : slot_r + SW'(1);

    // ==================================================
    // counters, slot enable pulse every SLOT_CYCLES
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cyc_r <= '0;
            slot_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cyc_r <= slot_end ? '0 : cyc_r + CW'(1);
            if (slot_end) begin
                slot_r <= slot_nxt;
            end
            tick_r <= period_end;
        end
    end

    // ==================================================
    // high for the first duty slots of each period
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            on_r <= 1'b0;
        end else begin
            on_r <= (SW'(tb.duty) > slot_r);
        end
    end

    assign tb.period_tick = tick_r;
    assign tb.pwm_on = on_r;
endmodule
`default_nettype wire

// file: rtl/fan_speed_fault_monitor.sv
// How it works
// [R1] ignore sense pulses right after pwm turns on
// [R2] 32 pulseless periods: pwm low, fault, latch
// [R3] fault clears only by shutdown toggle or reset
// [R4] fault output high while shut down
// [R5] alert low at high threshold plus 10
// [R6] full duty while alert is asserted
// [R7] alert releases at high threshold plus 5
// [R8] shutdown request holds pwm low
// [R9] alert keeps working during shutdown
// [R10] auto mode: fan off below low threshold
// [R11] auto mode restarts above first step threshold
// [R12] four equally spaced intermediate thresholds
// [R13] thresholds in 5 C steps, low 25-35
// [R14] high at least 10 above low
// [R15] duty steps of 10 percent per region
// [R16] pwm period about 15 Hz, timer base
// [R17] two second full kick on every start
// [R18] first stall retriggers kick, second latches
// [R19] digital temperature compared every period
`timescale 1ns/100ps
`default_nettype none
`include "fan_ctrl_defines.svh"
module fan_speed_fault_monitor
    import fan_ctrl_pkg::*;
#(
    parameter int SLOT_CYCLES = `SLOT_CYCLES,
    parameter int BLANK_CYCLES = `BLANK_CYCLES,
    parameter int STARTUP_PERIODS = `STARTUP_PERIODS,
    parameter int MISS_PERIODS = `MISS_PERIODS
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] temp_i,           // junction temp, deg C
    input wire logic sense_i,                // fan pulse train
    input wire logic fan_off_request_n_i,    // shutdown request
    output logic pwm_o,                      // fan drive
    output logic fan_fault_n_o,              // fan fault alert
    output logic overtemp_alert_n_o,         // over-temperature alert
    output logic irq_o,                      // level interrupt
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    localparam int BW = $clog2(BLANK_CYCLES + 1);
    localparam int KW = $clog2(STARTUP_PERIODS + 1);
    localparam int MW = $clog2(MISS_PERIODS + 1);

    pwm_tb_if tb();

    pwm_timebase #(
        .SLOT_CYCLES(SLOT_CYCLES),
        .SLOTS(`PWM_SLOTS)
    ) u_timebase (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .tb(tb.gen)
    ); // [R16]

    // ==================================================
    // state
    fan_state_t state_r, state_nxt;   // drive state
    logic [6:0] ctrl_r;               // mode and thresholds
    logic [`EV_WIDTH-1:0] status_r;   // sticky events
    logic [`EV_WIDTH-1:0] mask_r;     // interrupt enables
    duty_t duty_r;                    // duty of current period
    logic alert_r;                    // over-temp active
    logic [KW-1:0] kick_r;            // kick periods left
    logic [MW-1:0] miss_r;            // periods without pulse
    logic retry_r;                    // one retrigger used
    logic seen_r;                     // pulse in this period
    logic [BW-1:0] blank_r;           // blanking countdown
    logic sense_d_r;                  // sense delayed, edges
    logic wait_r;                     // bus wait state

    // ==================================================
    // thresholds from control fields
    wire auto_mode = ctrl_r[`CTRL_AUTO_BIT];
    wire [1:0] low_raw = ctrl_r[`CTRL_LOW_MSB:`CTRL_LOW_LSB];
    wire [2:0] span_raw = ctrl_r[`CTRL_SPAN_MSB:`CTRL_SPAN_LSB];
    // out-of-range codes clamp, keeping low 25-35 [R13]
    wire [1:0] low_code = (low_raw > `LOW_CODE_MAX) ?
        `LOW_CODE_MAX : low_raw; // [R13]
    wire [2:0] span_code = (span_raw > `SPAN_CODE_MAX) ?
        `SPAN_CODE_MAX : span_raw; // [R14]
    wire [7:0] low_threshold = `TL_BASE_C +
        8'(low_code) * `TH_STEP_C; // [R13]
    // span is 10 + 5n, never below 10 [R14]
    wire [7:0] high_threshold = low_threshold + `MIN_SPAN_C +
        8'(span_code) * `TH_STEP_C; // [R14]
    // a fifth of the span, exact since span is a multiple of 5
    wire [3:0] step_c = `STEP_BASE_C + 4'(span_code); // [R12]
    wire [7:0] first_step_threshold = low_threshold + 8'(step_c);
    wire [7:0] trip_c = high_threshold + `OVER_TRIP_C;
    wire [7:0] release_c = high_threshold + `OVER_HYST_C;

    // ==================================================
    // region count over the six thresholds
    logic [2:0] region;
    always_comb begin
        region = 3'h0;
        for (int k = 0; k < 5; k++) begin
            // intermediate thresholds low + k * step [R12]
            if (temp_i >= low_threshold + 8'(k) * 8'(step_c)) begin
                region = region + 3'h1;
            end
        end
        if (temp_i >= high_threshold) begin
            region = region + 3'h1;
        end
    end

    // region 0 is 40 percent or off, then 50..100 percent [R15]
    wire duty_t duty_tbl = (region == 3'h0) ?
        (auto_mode ? `DUTY_OFF : `DUTY_MIN) :
        duty_t'(region) + `DUTY_OFFSET; // [R15]

    // ==================================================
    // event decode
    wire tick = tb.period_tick;
    wire sense_edge = sense_i && !sense_d_r;
    wire pulse_ok = sense_edge && (blank_r == '0); // [R1]
    wire pulse_this = seen_r || pulse_ok;
    wire running = (state_r == ST_KICK) || (state_r == ST_RUN);
    wire stalled = running && tick && !pulse_this &&
        (miss_r == MW'(MISS_PERIODS - 1)); // [R2]
    wire alert_set = tick && !alert_r && (temp_i >= trip_c); // [R5]
    wire alert_clr = tick && alert_r && (temp_i <= release_c); // [R7]

    // ==================================================
    // drive state decisions
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_SHUT: begin
                // release from shutdown starts with a kick [R3]
                if (fan_off_request_n_i) begin
                    state_nxt = ST_KICK; // [R17]
                end
            end
            ST_FAULTED: begin
                state_nxt = ST_FAULTED; // [R2]
            end
            ST_AUTO_OFF: begin
                if (tick && (!auto_mode ||
                    temp_i > first_step_threshold)) begin
                    state_nxt = ST_KICK; // [R11]
                end
            end
            ST_KICK: begin
                if (stalled) begin
                    state_nxt = retry_r ? ST_FAULTED : ST_KICK; // [R18]
                end else if (tick && kick_r <= KW'(1)) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stalled) begin
                    state_nxt = retry_r ? ST_FAULTED : ST_KICK; // [R18]
                end else if (tick && auto_mode && region == 3'h0 &&
                    !alert_r) begin
                    state_nxt = ST_AUTO_OFF; // [R10]
                end
            end
            default: begin
                state_nxt = ST_SHUT;
            end
        endcase
        // request low wins over everything, clears the latch [R8]
        if (!fan_off_request_n_i) begin
            state_nxt = ST_SHUT; // [R3]
        end
    end

    wire kick_start = (state_nxt == ST_KICK) &&
        ((state_r != ST_KICK) || stalled);
    wire fault_ev = (state_nxt == ST_FAULTED) &&
        (state_r != ST_FAULTED);
    wire retry_ev = stalled && !retry_r && (state_nxt == ST_KICK);

    // pwm: low when stopped, full on kick or alert [R6]
    wire stopped = (state_nxt == ST_SHUT) ||
        (state_nxt == ST_FAULTED) || (state_nxt == ST_AUTO_OFF);
    wire pwm_nxt = stopped ? 1'b0 :
        ((state_nxt == ST_KICK) || alert_r || tb.pwm_on); // [R8]

    // ==================================================
    // state, kick and stall counters
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r <= ST_KICK;
            kick_r <= KW'(STARTUP_PERIODS);
            miss_r <= '0;
            retry_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            // kick lasts STARTUP_PERIODS periods [R17]
            if (kick_start) begin
                kick_r <= KW'(STARTUP_PERIODS); // [R17]
            end else if (tick && kick_r != '0) begin
                kick_r <= kick_r - KW'(1);
            end
            // count whole periods without a valid pulse [R2]
            if (!running || kick_start || pulse_this && tick) begin
                miss_r <= '0;
            end else if (tick) begin
                miss_r <= miss_r + MW'(1); // [R2]
            end
            // retry is rearmed by a good pulse or a shutdown [R18]
            if (retry_ev) begin
                retry_r <= 1'b1; // [R18]
            end else if (pulse_ok || state_r == ST_SHUT) begin
                retry_r <= 1'b0;
            end
        end
    end

    // ==================================================
    // pulse capture and blanking after pwm turn-on
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sense_d_r <= 1'b0;
            seen_r <= 1'b0;
            blank_r <= '0;
        end else begin
            sense_d_r <= sense_i;
            seen_r <= tick ? 1'b0 : pulse_this;
            if (pwm_nxt && !pwm_o) begin
                blank_r <= BW'(BLANK_CYCLES); // [R1]
            end else if (blank_r != '0) begin
                blank_r <= blank_r - BW'(1);
            end
        end
    end

    // ==================================================
    // temperature sampled once per period [R19]
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            duty_r <= `DUTY_FULL;
            alert_r <= 1'b0;
        end else begin
            if (tick) begin
                duty_r <= duty_tbl; // [R19]
            end
            // evaluated in every state, shutdown too [R9]
            if (alert_set) begin
                alert_r <= 1'b1; // [R5]
            end else if (alert_clr) begin
                alert_r <= 1'b0; // [R7]
            end
        end
    end

    assign tb.duty = duty_r;

    // ==================================================
    // pin outputs
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pwm_o <= 1'b0;
            fan_fault_n_o <= 1'b1;
            overtemp_alert_n_o <= 1'b1;
        end else begin
            pwm_o <= pwm_nxt;
            // low only while latched; shutdown state forces high [R4]
            fan_fault_n_o <= (state_nxt != ST_FAULTED); // [R4]
            overtemp_alert_n_o <= !(alert_r || alert_set) ||
                alert_clr; // [R9]
        end
    end

    // ==================================================
    // register bus decode
    wire req = avs_read_i || avs_write_i;
    wire take = req && !wait_r;
    wire sel_ctrl = (avs_address_i == `REG_CTRL_OFS);
    wire sel_status = (avs_address_i == `REG_STATUS_OFS);
    wire sel_mask = (avs_address_i == `REG_MASK_OFS);
    wire sel_state = (avs_address_i == `REG_STATE_OFS);
    wire wr_lane0 = take && avs_write_i && avs_byteenable_i[0];
    wire [`EV_WIDTH-1:0] events = {retry_ev, kick_start,
        alert_clr, alert_set, fault_ev};
    wire [`EV_WIDTH-1:0] w1c = (wr_lane0 && sel_status) ?
        avs_writedata_i[`EV_WIDTH-1:0] : '0;
    wire [`EV_WIDTH-1:0] status_nxt = (status_r & ~w1c) | events;
    wire [31:0] state_word = {8'h00, temp_i, 7'h00,
        (state_r == ST_KICK), (state_r == ST_AUTO_OFF),
        (state_r == ST_SHUT), (state_r == ST_FAULTED),
        alert_r, duty_r};
    wire [31:0] rd_mux = sel_ctrl ? {25'h0, ctrl_r} :
        sel_status ? {27'h0, status_r} :
        sel_mask ? {27'h0, mask_r} :
        sel_state ? state_word : 32'h0000_0000;

    // ==================================================
    // one wait cycle, then the request is taken
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wait_r <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            wait_r <= !(req && wait_r);
            if (req && wait_r) begin
                avs_readdata_o <= rd_mux;
            end
        end
    end

    assign avs_waitrequest_o = wait_r;

    // ==================================================
    // registers and interrupt, event set beats clear
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ctrl_r <= `CTRL_RESET;
            mask_r <= `EV_RESET;
            status_r <= `EV_RESET;
            irq_o <= 1'b0;
        end else begin
            if (wr_lane0 && sel_ctrl) begin
                ctrl_r <= avs_writedata_i[6:0];
            end
            if (wr_lane0 && sel_mask) begin
                mask_r <= avs_writedata_i[`EV_WIDTH-1:0];
            end
            status_r <= status_nxt;
            irq_o <= |(status_nxt & mask_r);
        end
    end
endmodule
`default_nettype wire

// file: sim/fan_speed_fault_monitor_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// port checker
module fan_monitor_sva (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] temp_i,
    input wire logic fan_off_request_n_i,
    input wire logic pwm_o,
    input wire logic fan_fault_n_o,
    input wire logic overtemp_alert_n_o,
    input wire logic irq_o,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic avs_waitrequest_o
);
    logic [6:0] ctrl_r; // shadow of control word
    logic ctrl_we; // accepted control write
    logic [7:0] low_c, span_c, trip_c, rel_c; // thresholds
    assign ctrl_we = avs_write_i && !avs_waitrequest_o
        && avs_address_i == 4'h0 && avs_byteenable_i[0];
    assign low_c = 8'h19 + (ctrl_r[3] ? 8'h0A : (ctrl_r[2] ? 8'h05 : 8'h00));
    assign span_c = (ctrl_r[6:4] > 3'h4) ? 8'h14 : 8'h05 * ctrl_r[6:4];
    assign trip_c = low_c + span_c + 8'h14;
    assign rel_c = trip_c - 8'h05;
    // track control writes so thresholds follow the bus
    always_ff @(posedge mclk_i) begin
        if (rst_i)
            ctrl_r <= 7'h00;
        else if (ctrl_we)
            ctrl_r <= avs_writedata_i[6:0];
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    property p_shut_pwm;
        !fan_off_request_n_i |=> !pwm_o;
    endproperty
    a_shut_pwm: assert property (p_shut_pwm)
        else $error("pwm on in shutdown");
    property p_shut_fault;
        !fan_off_request_n_i |=> fan_fault_n_o;
    endproperty
    a_shut_fault: assert property (p_shut_fault)
        else $error("fault low in shutdown");
    property p_fault_pwm;
        !fan_fault_n_o [*3] |-> !pwm_o;
    endproperty
    a_fault_pwm: assert property (p_fault_pwm)
        else $error("pwm on while faulted");
    property p_fault_hold;
        !fan_fault_n_o && fan_off_request_n_i |=> !fan_fault_n_o;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault released without toggle");
    property p_alert_full;
        (!overtemp_alert_n_o && fan_off_request_n_i && fan_fault_n_o) [*3]
            |-> pwm_o;
    endproperty
    a_alert_full: assert property (p_alert_full)
        else $error("pwm not full under alert");
    property p_alert_trip;
        $fell(overtemp_alert_n_o)
            |-> $past(temp_i) >= trip_c || $past(temp_i, 2) >= trip_c;
    endproperty
    a_alert_trip: assert property (p_alert_trip)
        else $error("alert set below trip");
    property p_alert_rel;
        $rose(overtemp_alert_n_o)
            |-> $past(temp_i) <= rel_c || $past(temp_i, 2) <= rel_c;
    endproperty
    a_alert_rel: assert property (p_alert_rel)
        else $error("alert released above hysteresis");
    property p_kick;
        $rose(fan_off_request_n_i) |-> ##[1:3] pwm_o [*8];
    endproperty
    a_kick: assert property (p_kick)
        else $error("no full drive after restart");
    c_fault: cover property ($fell(fan_fault_n_o));
    c_alert: cover property ($fell(overtemp_alert_n_o));
    c_irq: cover property ($rose(irq_o));
endmodule
bind fan_speed_fault_monitor fan_monitor_sva fan_monitor_sva_inst (
    .mclk_i, .rst_i, .temp_i, .fan_off_request_n_i, .pwm_o, .fan_fault_n_o,
    .overtemp_alert_n_o, .irq_o, .avs_address_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o);
`default_nettype wire

// file: sim/fan_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// fan behind a low-side switch
module fan_model #(
    parameter int GAP = 16
) (
    input wire logic mclk_i,
    input wire logic pwm_i, // switch drive
    input wire logic spin_i, // rotor free to turn
    output logic sense_o // sense pulses
);
    logic pwm_q = 1'b0; // drive one clock back
    logic pulse_r = 1'b0; // sense pulse
    logic [7:0] gap_r = 8'h00; // commutation spacing
    assign sense_o = pulse_r;
    // pulses only while current flows, line idles low
    always @(posedge mclk_i) begin
        pwm_q <= pwm_i;
        gap_r <= (gap_r == 8'(GAP - 1)) ? 8'h00 : gap_r + 8'h01;
        if (pwm_i && !pwm_q)
            pulse_r <= 1'b1; // turn-on spike to be blanked
        else
            pulse_r <= pwm_i && spin_i && gap_r == 8'h00;
    end
endmodule
`default_nettype wire

// file: sim/fan_speed_fault_monitor_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// directed bench
module fan_speed_fault_monitor_tb;
    import fan_ctrl_pkg::*;
    localparam int PER = 100; // pwm period in clocks
    // temps and duties; rows 7 up use control 7C
    localparam logic [7:0] TT [11] = '{8'h14, 8'h19, 8'h1B, 8'h1D, 8'h1F,
        8'h21, 8'h23, 8'h22, 8'h28, 8'h29, 8'h41};
    localparam duty_t DT [11] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
        4'hA, 4'h4, 4'h5, 4'h6, 4'hA};
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] temp_i = 8'h14;
    logic req_n = 1'b1; // shutdown request
    logic spin = 1'b1; // fan turning
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rword;
    logic sense_i, pwm_o, fault_n, alert_n, irq_o, wreq;
    int err_total = 0;
    int check_count = 0;
    always #10 mclk_i = ~mclk_i;
    fan_speed_fault_monitor #(.SLOT_CYCLES(10), .BLANK_CYCLES(3),
        .STARTUP_PERIODS(3), .MISS_PERIODS(4)) fan_speed_fault_monitor_inst (
        .mclk_i, .rst_i, .temp_i, .sense_i, .fan_off_request_n_i(req_n),
        .pwm_o, .fan_fault_n_o(fault_n), .overtemp_alert_n_o(alert_n),
        .irq_o, .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq));
    fan_model fan_model_inst (.mclk_i, .pwm_i(pwm_o), .spin_i(spin),
        .sense_o(sense_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic hang;
        err_total++;
        $display("unexpected at %0t: wait ran out", $time);
        conclude();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // one bus access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        rword = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50)
            hang();
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] m,
            input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rword & m, e);
    endtask
    task automatic pwm_count(output int c);
        c = 0;
        repeat (PER) begin
            @(posedge mclk_i);
            c += (pwm_o === 1'b1);
        end
    endtask
    // high time over one period and reported duty
    task automatic duty_chk(input duty_t d);
        int c;
        pwm_count(c);
        chk(c, 10 * d);
        rchk(4'hC, 32'hF, {28'h0, d});
    endtask
    task automatic t_reset;
        int c;
        cyc(2);
        pwm_count(c);
        chk(c, PER);
        bus(1'b1, 4'h2, 32'hFF); // unmapped, dropped
        rchk(4'h0, 32'hFFFFFFFF, 32'h0);
        rchk(4'h2, 32'hFFFFFFFF, 32'h0);
        rchk(4'h8, 32'hFFFFFFFF, 32'h0);
        cyc(3 * PER);
    endtask
    task automatic t_duty;
        for (int i = 0; i < 11; i++) begin
            bus(1'b1, 4'h0, (i < 7) ? 32'h0 : 32'h7C);
            temp_i <= TT[i];
            cyc(2 * PER);
            duty_chk(DT[i]);
        end
    endtask
    task automatic t_alert;
        int c;
        // cool below the new trip point before the thresholds drop
        temp_i <= 8'h2C;
        bus(1'b1, 4'h0, 32'h0);
        bus(1'b1, 4'h4, 32'h1F);
        bus(1'b1, 4'h8, 32'h2); // interrupt on alert only
        cyc(2 * PER);
        chk(alert_n, 1'b1);
        temp_i <= 8'h2D;
        cyc(2 * PER);
        chk({alert_n, irq_o}, 2'h1);
        duty_chk(4'hA);
        req_n <= 1'b0; // shut down while hot
        cyc(2 * PER);
        pwm_count(c);
        chk(c, 0);
        chk({fault_n, alert_n}, 2'h2);
        temp_i <= 8'h29;
        cyc(2 * PER);
        chk(alert_n, 1'b0);
        temp_i <= 8'h28;
        cyc(2 * PER);
        chk(alert_n, 1'b1);
        req_n <= 1'b1;
        rchk(4'h4, 32'h6, 32'h6);
        bus(1'b1, 4'h4, 32'h2);
        cyc(2);
        chk({irq_o, pwm_o}, 2'h1);
        bus(1'b1, 4'h8, 32'h0);
        temp_i <= 8'h14;
        cyc(4 * PER);
    endtask
    // rotor stops; only turn-on spikes reach the sense line
    task automatic t_stall;
        int n;
        bus(1'b1, 4'h4, 32'h1F);
        spin <= 1'b0;
        n = 0;
        while (fault_n !== 1'b0 && n < 2000) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 2000)
            hang();
        chk(n >= 6 * PER && n <= 11 * PER, 1'b1);
        rchk(4'h4, 32'h11, 32'h11);
        spin <= 1'b1;
        cyc(2 * PER);
        chk({fault_n, pwm_o}, 2'h0);
        req_n <= 1'b0;
        cyc(4);
        chk(fault_n, 1'b1);
        req_n <= 1'b1;
        cyc(6 * PER);
        chk(fault_n, 1'b1);
    endtask
    task automatic t_auto;
        int c;
        bus(1'b1, 4'h0, 32'h1); // auto-off mode at 20
        cyc(2 * PER);
        duty_chk(4'h0);
        rchk(4'hC, 32'h80, 32'h80);
        temp_i <= 8'h1B;
        cyc(2 * PER);
        pwm_count(c);
        chk(c, 0);
        // duty field tracks the region while the fan stays off
        rchk(4'hC, 32'h8F, 32'h86);
        temp_i <= 8'h1C;
        cyc(PER + PER / 2);
        pwm_count(c);
        chk(c, PER);
    endtask
    initial begin
        cyc(4);
        rst_i <= 1'b0;
        t_reset();
        t_duty();
        t_alert();
        t_stall();
        t_auto();
        conclude();
    end
endmodule
`default_nettype wire
